// *** verilog/lintc_pkg.sv ***
package lintc_pkg;
    localparam int CLK_MHZ = 125;
    // Register byte addresses on the Wishbone slave
    localparam logic [3:0] ADDR_MODE   = 4'h0;
    localparam logic [3:0] ADDR_RATE   = 4'h4;
    localparam logic [3:0] ADDR_INTSET = 4'h8;
    localparam logic [3:0] ADDR_DIAG   = 4'hC;
    // Mode field encodings
    localparam logic [1:0] MODE_SLEEP_NOWU = 2'h0;
    localparam logic [1:0] MODE_LISTEN     = 2'h1;
    localparam logic [1:0] MODE_SLEEP_WU   = 2'h2;
    localparam logic [1:0] MODE_NORMAL     = 2'h3;
    localparam logic [1:0] MODE_RESET      = 2'h3;
    // Bit-rate encodings
    localparam logic [1:0] RATE_NORMAL = 2'h0;
    localparam logic [1:0] RATE_SLOW   = 2'h1;
    localparam logic [1:0] RATE_FAST   = 2'h2;
    localparam logic [1:0] RATE_RESET  = 2'h0;
    // Slope codes driven to the analog driver
    localparam logic [1:0] SLOPE_20K  = 2'h0;
    localparam logic [1:0] SLOPE_10K  = 2'h1;
    localparam logic [1:0] SLOPE_FAST = 2'h2;
    // Diagnostic flag and interrupt-setting bit positions
    localparam int DIAG_TXDOM  = 0;
    localparam int DIAG_RXREC  = 1;
    localparam int DIAG_BUSDOM = 2;
    localparam int DIAG_OT     = 3;
    localparam int DIAG_WAKE   = 4;
    localparam int INTSET_INH  = 0;
    localparam int INIT_DONE   = 2;
    // Timing in microseconds, its clock-cycle equivalents, and the receive-check edge count
    localparam int TXDOM_US  = 20000;
    localparam int SHORT_US  = 20000;
    localparam int WAKEUP_US = 150;
    localparam int TXDOM_CYC  = TXDOM_US * CLK_MHZ;
    localparam int SHORT_CYC  = SHORT_US * CLK_MHZ;
    localparam int WAKEUP_CYC = WAKEUP_US * CLK_MHZ;
    localparam int RXREC_CNT  = 7;
endpackage

// *** verilog/lintc_core.sv ***
// Notes on behaviour
// - Normal mode (11): transmit input drives bus, bus level goes to receive output.
// - Normal mode: transmit high means driver off, low means driver on.
// - Listen mode (01): driver off, transmit input watched only by the fault checks, receive output reports bus.
// - Low-power-off entry forces sleep; mode bits decide wake capability.
// - Asleep: transmit and receive pins both pulled low.
// - Rates 20, 10, 100 kB/s; set only during initialisation.
// - Slope follows configured bit-rate automatically.
// - Supply undervoltage forces bus recessive.
// - Transmit low beyond timeout disables driver; receiver keeps working.
// - Transmit timeout clears mode MSB and sets transmit stuck flag.
// - Recovery needs mode rewritten to normal, then transmit input high.
// - Transmit timeout supervision runs only in normal or listen mode.
// - Receive high through seven dominant transmit cycles disables driver and receiver.
// - Receive failure clears mode MSB, sets flag; recovers on normal rewrite and transmit high.
// - Bus dominant beyond short time reports bus error, in normal or listen.
// - Current limit holds bus recessive, then resumes former mode.
// - Overtemperature disables driver, clears mode MSB, sets overtemp flag.
// - After overtemp, stay off until cooled, then normal rewrite and transmit high.
// - Inhibit bit set suppresses interrupt from the four bus errors.
// - Asleep with wake: wake only on fall, dominant beyond wake time, rise.
//
// Chosen here: the Wishbone slave port and the register offsets.
module lintc_core #(
    parameter int TXDOM_CYCLES  = lintc_pkg::TXDOM_CYC,
    parameter int SHORT_CYCLES  = lintc_pkg::SHORT_CYC,
    parameter int WAKEUP_CYCLES = lintc_pkg::WAKEUP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        transmit_data_input,
    output logic             receive_data_output,
    input  wire logic        bus_level_i,
    output logic             bus_drive_o,
    output logic             receiver_en_o,
    output logic [1:0]       slope_o,
    input  wire logic        low_power_off_state,
    input  wire logic        supply_uv_i,
    input  wire logic        current_limit_i,
    input  wire logic        overtemp_i,
    input  wire logic        overtemp_cool_i,
    output logic             txd_pulldown_o,
    output logic             error_irq_o
);
    // bus_level_i: 1 = recessive, 0 = dominant
    logic [1:0]  mode;
    logic [1:0]  rate;
    logic        irq_inh;
    logic        init_done;
    logic [4:0]  diag;
    logic        drv_block;
    logic        rx_block;
    logic        ot_hold;
    logic        mode_rewr;
    logic [31:0] txdom_cnt;
    logic [31:0] short_cnt;
    logic [31:0] wake_cnt;
    logic        wake_armed;
    logic [2:0]  rxrec_cnt;
    logic        txd_q;
    logic        bus_q;
    logic [3:0]  err_q;

    wire         wb_req   = cyc_i && stb_i && !ack_o;
    wire         wb_wr    = wb_req && we_i && sel_i[0];
    wire         asleep   = low_power_off_state;
    wire         wake_en  = mode[1] && !mode[0];
    wire         active   = !asleep && mode[0];
    wire         normal   = !asleep && (mode == lintc_pkg::MODE_NORMAL);
    wire         txd_eff  = normal ? transmit_data_input : 1'b1;
    // Fires once per stuck-low stretch, so a mode rewrite during the stretch is not undone
    wire         tx_to    = active && !transmit_data_input && txdom_cnt == 32'(TXDOM_CYCLES - 1);
    wire         rx_fail  = active && rxrec_cnt == 3'(lintc_pkg::RXREC_CNT - 1) &&
                            txd_q && !transmit_data_input && bus_q;
    wire         bus_short = active && !bus_level_i && short_cnt >= 32'(SHORT_CYCLES - 1);
    wire         ot_evt   = overtemp_i && !ot_hold;
    wire [4:0]   diag_set = {1'b0, ot_evt, bus_short, rx_fail, tx_to};
    wire         wake_evt = asleep && wake_en && wake_armed && bus_level_i && !bus_q &&
                            wake_cnt >= 32'(WAKEUP_CYCLES);

    // Wishbone slave, one registered ack per request, a cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= wb_req;
            dat_o <= 32'h0;
            if (wb_req && !we_i) begin
                unique case (adr_i)
                    lintc_pkg::ADDR_MODE:   dat_o <= {30'h0, mode};
                    lintc_pkg::ADDR_RATE:   dat_o <= {30'h0, rate};
                    lintc_pkg::ADDR_INTSET: dat_o <= {29'h0, init_done, 1'b0, irq_inh};
                    lintc_pkg::ADDR_DIAG:   dat_o <= {27'h0, diag};
                    default:                dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Mode register; faults knock out the MSB and win over a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode      <= lintc_pkg::MODE_RESET;
            mode_rewr <= 1'b0;
        end else begin
            if (wb_wr && adr_i == lintc_pkg::ADDR_MODE) begin
                mode      <= dat_i[1:0];
                mode_rewr <= dat_i[1:0] == lintc_pkg::MODE_NORMAL;
            end
            if (tx_to || rx_fail || ot_evt) begin
                mode[1]   <= 1'b0;
                mode_rewr <= 1'b0;
            end
        end
    end

    // Rate and inhibit; rate frozen once init closes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate      <= lintc_pkg::RATE_RESET;
            irq_inh   <= 1'b0;
            init_done <= 1'b0;
        end else if (wb_wr && adr_i == lintc_pkg::ADDR_RATE && !init_done) begin
            rate      <= (dat_i[1:0] == 2'h3) ? lintc_pkg::RATE_NORMAL : dat_i[1:0];
        end else if (wb_wr && adr_i == lintc_pkg::ADDR_INTSET) begin
            irq_inh   <= dat_i[lintc_pkg::INTSET_INH];
            init_done <= init_done | dat_i[lintc_pkg::INIT_DONE];
        end
    end

    // Sticky diagnostics, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            diag <= 5'h0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (diag_set[i] || (i == lintc_pkg::DIAG_WAKE && wake_evt))
                    diag[i] <= 1'b1;
                else if (wb_wr && adr_i == lintc_pkg::ADDR_DIAG && dat_i[i])
                    diag[i] <= 1'b0;
            end
        end
    end

    // Transmit and bus-dominant timers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txdom_cnt <= 32'h0;
            short_cnt <= 32'h0;
        end else begin
            if (!active || transmit_data_input)
                txdom_cnt <= 32'h0;
            else if (txdom_cnt < 32'(TXDOM_CYCLES))
                txdom_cnt <= txdom_cnt + 32'h1;
            short_cnt <= (active && !bus_level_i && !bus_short) ? short_cnt + 32'h1 : 32'h0;
        end
    end

    // Receive stuck check: count dominant transmit bits seen as recessive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txd_q     <= 1'b1;
            bus_q     <= 1'b1;
            rxrec_cnt <= 3'h0;
        end else begin
            txd_q <= transmit_data_input;
            bus_q <= bus_level_i;
            if (!active)
                rxrec_cnt <= 3'h0;
            else if (!transmit_data_input && !bus_level_i)
                rxrec_cnt <= 3'h0;
            // Restart the count after a trip, else the next edge trips again
            else if (rx_fail)
                rxrec_cnt <= 3'h0;
            else if (txd_q && !transmit_data_input && bus_q && !rx_fail)
                rxrec_cnt <= rxrec_cnt + 3'h1;
        end
    end

    // Driver blocks and recovery
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_block <= 1'b0;
            rx_block  <= 1'b0;
            ot_hold   <= 1'b0;
        end else begin
            if (ot_evt)
                ot_hold <= 1'b1;
            else if (ot_hold && overtemp_cool_i)
                ot_hold <= 1'b0;
            if (tx_to || rx_fail || ot_evt) begin
                drv_block <= 1'b1;
                rx_block  <= rx_block | rx_fail;
            end else if (drv_block && mode_rewr && normal && transmit_data_input && !ot_hold) begin
                drv_block <= 1'b0;
                rx_block  <= 1'b0;
            end
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_drive_o         <= 1'b0;
            receive_data_output <= 1'b1;
            receiver_en_o       <= 1'b0;
            txd_pulldown_o      <= 1'b0;
            slope_o             <= lintc_pkg::SLOPE_20K;
        end else begin
            // Current limit only masks drive, mode state untouched
            bus_drive_o <= normal && !txd_eff && !drv_block && !supply_uv_i &&
                           !current_limit_i && !ot_hold;
            receiver_en_o       <= active && !rx_block;
            receive_data_output <= asleep ? 1'b0 : (rx_block ? 1'b1 : bus_level_i);
            txd_pulldown_o      <= asleep;
            unique case (rate)
                lintc_pkg::RATE_SLOW: slope_o <= lintc_pkg::SLOPE_10K;
                lintc_pkg::RATE_FAST: slope_o <= lintc_pkg::SLOPE_FAST;
                default:              slope_o <= lintc_pkg::SLOPE_20K;
            endcase
        end
    end

    // Wake pulse timing and error interrupt pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_cnt    <= 32'h0;
            wake_armed  <= 1'b0;
            err_q       <= 4'h0;
            error_irq_o <= 1'b0;
        end else begin
            if (bus_q && !bus_level_i)
                wake_armed <= asleep;
            else if (bus_level_i)
                wake_armed <= 1'b0;
            wake_cnt <= (!bus_level_i && wake_cnt < 32'(WAKEUP_CYCLES)) ? wake_cnt + 32'h1 :
                        (bus_level_i ? 32'h0 : wake_cnt);
            err_q       <= diag[3:0];
            error_irq_o <= |(diag[3:0] & ~err_q) && !irq_inh;
        end
    end

    drive_off_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power_off_state |=> !bus_drive_o && !receive_data_output)
        else $error("driver or receive active while asleep");
    uv_recessive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        supply_uv_i |=> !bus_drive_o)
        else $error("bus driven under undervoltage");
    climit_recess_a: assert property (@(posedge clk_i) disable iff (rst_i)
        current_limit_i |=> !bus_drive_o)
        else $error("bus driven in current limit");
    txto_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_to |=> diag[lintc_pkg::DIAG_TXDOM] && !mode[1] ##1 !bus_drive_o)
        else $error("transmit timeout not flagged");
    rxfail_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_fail |=> diag[lintc_pkg::DIAG_RXREC] && rx_block)
        else $error("receive failure not flagged");
    ot_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ot_hold |=> !bus_drive_o)
        else $error("driver on during overtemp hold");
    listen_nodrive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == lintc_pkg::MODE_LISTEN) |=> !bus_drive_o)
        else $error("driver on in listen mode");
    normal_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (normal && !drv_block && !supply_uv_i && !current_limit_i && !ot_hold && !transmit_data_input)
        |=> bus_drive_o)
        else $error("driver not following transmit low");
    inh_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_inh |=> !error_irq_o)
        else $error("interrupt raised while inhibited");
    slope_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rate == lintc_pkg::RATE_SLOW) |=> slope_o == lintc_pkg::SLOPE_10K)
        else $error("slope does not follow rate");


    // Pin-level checks and the rate lock
    sleep_pulldown_a: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power_off_state |=> txd_pulldown_o)
        else $error("pull-down off while asleep");
    sleep_rx_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        low_power_off_state |=> !receiver_en_o)
        else $error("receiver running while asleep");
    normal_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (normal && !rx_block) |=> receive_data_output == $past(bus_level_i))
        else $error("receive output not following bus in normal mode");
    listen_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!asleep && mode == lintc_pkg::MODE_LISTEN && !rx_block) |=> receive_data_output == $past(bus_level_i))
        else $error("receive output not following bus in listen mode");
    normal_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (normal && transmit_data_input) |=> !bus_drive_o)
        else $error("driver on with transmit high");
    only_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !normal |=> !bus_drive_o)
        else $error("driver on outside normal mode");
    fast_slope_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rate == lintc_pkg::RATE_FAST) |=> slope_o == lintc_pkg::SLOPE_FAST)
        else $error("fast slope not selected");
    rate_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        init_done |=> $stable(rate))
        else $error("rate changed after initialisation");

    // Fault and flag checks
    txto_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_to |=> !tx_to && drv_block)
        else $error("transmit timeout not single or driver not blocked");
    rx_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && !rx_block) |=> receiver_en_o)
        else $error("receiver stopped without receive fault");
    rxfail_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_fail |=> ##1 !receiver_en_o)
        else $error("receiver still on after receive failure");
    rxblock_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_block && !asleep) |=> receive_data_output)
        else $error("receive output not held recessive while blocked");
    short_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_short |=> diag[lintc_pkg::DIAG_BUSDOM])
        else $error("bus short not flagged");
    ot_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ot_evt |=> diag[lintc_pkg::DIAG_OT] && !mode[1] && ot_hold)
        else $error("overtemperature not flagged");
    flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (diag[lintc_pkg::DIAG_TXDOM] && !(wb_wr && adr_i == lintc_pkg::ADDR_DIAG)) |=> diag[lintc_pkg::DIAG_TXDOM])
        else $error("transmit stuck flag lost without clear");
    wake_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_evt |=> diag[lintc_pkg::DIAG_WAKE])
        else $error("wake event not flagged");
    wake_awake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !asleep |=> !$rose(diag[lintc_pkg::DIAG_WAKE]))
        else $error("wake flagged while awake");

    // Register bus handshake
    wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> ack_o)
        else $error("request not acknowledged");
    wb_ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");

    txto_cov: cover property (@(posedge clk_i) tx_to);
    ot_cov: cover property (@(posedge clk_i) ot_evt);
    rxfail_cov: cover property (@(posedge clk_i) rx_fail);
    wake_cov: cover property (@(posedge clk_i) wake_evt);
    short_cov: cover property (@(posedge clk_i) bus_short);
endmodule

// *** test/lintc_bus_model.sv ***
module lintc_bus_model (
    input  wire logic clk_i,
    input  wire logic txd_req_i,
    input  wire logic drive_i,
    input  wire logic open_i,
    input  wire logic ext_dom_i,
    output logic      txd_o,
    output logic      bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Controller raises its transmit line to release a fault latch
    assign txd_o = txd_req_i;
    // Pull-up holds the wire recessive once nobody drives; open_i cuts our own driver off
    assign bus_o = ~((drive_i & ~open_i) | ext_dom_i);
endmodule

// *** test/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, txd_req = 1'b1, txd, bus, drive, rx, rx_en, pd, irq;
    logic lpo = 1'b0, uv = 1'b0, cl = 1'b0, ot = 1'b0, cool = 1'b1, open_w = 1'b0, ext = 1'b0;
    logic [1:0] slope;
    int err_count = 0, n_tests = 0, irq_n = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (error_irq_o_seen()) irq_n++;
    function automatic bit error_irq_o_seen();
        return irq === 1'b1;
    endfunction
    lintc_core #(.TXDOM_CYCLES(50), .SHORT_CYCLES(60), .WAKEUP_CYCLES(20)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .transmit_data_input(txd),
        .receive_data_output(rx), .bus_level_i(bus), .bus_drive_o(drive), .receiver_en_o(rx_en),
        .slope_o(slope), .low_power_off_state(lpo), .supply_uv_i(uv), .current_limit_i(cl),
        .overtemp_i(ot), .overtemp_cool_i(cool), .txd_pulldown_o(pd), .error_irq_o(irq));
    lintc_bus_model partner (.clk_i(clk_i), .txd_req_i(txd_req), .drive_i(drive), .open_i(open_w),
        .ext_dom_i(ext), .txd_o(txd), .bus_o(bus));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr_i <= a; dat_i <= d; we_i <= w; cyc_i <= 1'b1; stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic set_txd(input logic v, input int n);
        txd_req <= v;
        tick(n);
    endtask
    task automatic t_normal();
        wb(0, lintc_pkg::ADDR_MODE, 32'h0);
        chk("mode_rst", {30'h0, lintc_pkg::MODE_RESET}, q & 32'h3);
        set_txd(0, 3);
        chk("drive_on", 32'h1, drive);
        chk("rx_dom", 32'h0, rx);
        cl <= 1'b1; tick(3);
        chk("drive_cl", 32'h0, drive);
        cl <= 1'b0; tick(3);
        chk("drive_resume", 32'h1, drive);
        uv <= 1'b1; tick(3);
        chk("drive_uv", 32'h0, drive);
        uv <= 1'b0; set_txd(1, 3);
        chk("drive_off", 32'h0, drive);
        chk("rx_rec", 32'h1, rx);
    endtask
    task automatic t_short();
        ext <= 1'b1; tick(70); ext <= 1'b0; tick(2);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("busdom", 32'h1, q[lintc_pkg::DIAG_BUSDOM]);
        wb(1, lintc_pkg::ADDR_DIAG, 32'h1F);
    endtask
    task automatic t_timeout();
        int i0;
        i0 = irq_n;
        set_txd(0, 60);
        chk("drive_to", 32'h0, drive);
        chk("rx_to", 32'h1, rx);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("txdom", 32'h1, q[lintc_pkg::DIAG_TXDOM]);
        chk("irq_one", 1, irq_n - i0);
        wb(0, lintc_pkg::ADDR_MODE, 32'h0);
        chk("mode_msb", {30'h0, lintc_pkg::MODE_LISTEN}, q & 32'h3);
        wb(1, lintc_pkg::ADDR_MODE, 32'h3); tick(3);
        chk("drive_held", 32'h0, drive);
        set_txd(1, 2);
        set_txd(0, 3);
        chk("drive_back", 32'h1, drive);
        set_txd(1, 2);
        wb(1, lintc_pkg::ADDR_DIAG, 32'h1F);
    endtask
    task automatic t_listen();
        wb(1, lintc_pkg::ADDR_MODE, {30'h0, lintc_pkg::MODE_LISTEN});
        set_txd(0, 3);
        chk("drive_listen", 32'h0, drive);
        tick(60);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("txdom_listen", 32'h1, q[lintc_pkg::DIAG_TXDOM]);
        set_txd(1, 2);
        wb(1, lintc_pkg::ADDR_DIAG, 32'h1F);
        wb(1, lintc_pkg::ADDR_MODE, 32'h3);
    endtask
    task automatic t_overtemp();
        int i0;
        wb(1, lintc_pkg::ADDR_INTSET, 32'h1);
        i0 = irq_n;
        set_txd(0, 2);
        ot <= 1'b1; cool <= 1'b0; tick(3);
        chk("drive_ot", 32'h0, drive);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("ot_flag", 32'h1, q[lintc_pkg::DIAG_OT]);
        chk("irq_inh", 0, irq_n - i0);
        ot <= 1'b0; set_txd(1, 2);
        wb(1, lintc_pkg::ADDR_MODE, 32'h3);
        set_txd(0, 3);
        chk("drive_hot", 32'h0, drive);
        cool <= 1'b1; set_txd(1, 2);
        set_txd(0, 3);
        chk("drive_cool", 32'h1, drive);
        set_txd(1, 2);
        wb(1, lintc_pkg::ADDR_DIAG, 32'h1F);
    endtask
    task automatic t_rxstuck();
        open_w <= 1'b1;
        repeat (7) begin
            set_txd(0, 2);
            set_txd(1, 2);
        end
        chk("rx_en_off", 32'h0, rx_en);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("rxrec", 32'h1, q[lintc_pkg::DIAG_RXREC]);
        open_w <= 1'b0;
        wb(1, lintc_pkg::ADDR_MODE, 32'h3); tick(3);
        chk("rx_en_back", 32'h1, rx_en);
    endtask
    task automatic t_rate();
        wb(1, lintc_pkg::ADDR_RATE, {30'h0, lintc_pkg::RATE_SLOW}); tick(2);
        chk("slope_slow", {30'h0, lintc_pkg::SLOPE_10K}, slope);
        wb(1, lintc_pkg::ADDR_RATE, {30'h0, lintc_pkg::RATE_FAST}); tick(2);
        chk("slope_fast", {30'h0, lintc_pkg::SLOPE_FAST}, slope);
        wb(1, lintc_pkg::ADDR_INTSET, 32'h5);
        wb(1, lintc_pkg::ADDR_RATE, 32'h0); tick(2);
        chk("rate_locked", {30'h0, lintc_pkg::SLOPE_FAST}, slope);
    endtask
    task automatic t_sleep();
        wb(1, lintc_pkg::ADDR_MODE, {30'h0, lintc_pkg::MODE_SLEEP_WU});
        lpo <= 1'b1; tick(3);
        chk("pulldown", 32'h1, pd);
        chk("rx_sleep", 32'h0, rx);
        ext <= 1'b1; tick(30); ext <= 1'b0; tick(3);
        wb(0, lintc_pkg::ADDR_DIAG, 32'h0);
        chk("wake", 32'h1, q[lintc_pkg::DIAG_WAKE]);
        wb(0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        t_normal(); t_short(); t_timeout(); t_listen();
        t_overtemp(); t_rxstuck(); t_rate(); t_sleep();
        tally_and_finish();
    end
endmodule
